/* File: rtl/hscl_pkg.sv */
/*
  Shared constants of the field switch configuration and lock block:
  command addresses, field widths, reset values and datapath scaling.
  Assumes a telegram decoder on the same clock delivers decoded commands.
*/
package hscl_pkg;

  localparam int DATA_W    = 14;
  localparam int ADDR_W    = 4;
  localparam int UIB_W     = 13;
  localparam int UIB_COUNT = 4;
  localparam int OFFS_W    = 12;
  localparam int GAIN_W    = 14;
  localparam int LEVEL_W   = 9;
  localparam int FMT_W     = 3;
  localparam int LOCK_W    = 2;

  // Command addresses of the programmable registers and the read-only readouts
  localparam logic [3:0] ADDR_FORMAT  = 4'h0;
  localparam logic [3:0] ADDR_OFFSET  = 4'h1;
  localparam logic [3:0] ADDR_GAIN    = 4'h2;
  localparam logic [3:0] ADDR_RELEASE = 4'h3;
  localparam logic [3:0] ADDR_OPERATE = 4'h4;
  localparam logic [3:0] ADDR_UIB0    = 4'h5;
  localparam logic [3:0] ADDR_UIB3    = 4'h8;
  localparam logic [3:0] ADDR_LOCK    = 4'h9;
  localparam logic [3:0] ADDR_RAW     = 4'hA;
  localparam logic [3:0] ADDR_PROC    = 4'hB;

  // Values after reset
  localparam logic [2:0]  FORMAT_RESET  = 3'h4;
  localparam logic [11:0] OFFSET_RESET  = 12'h800;
  localparam logic [13:0] GAIN_RESET    = 14'h0266;
  localparam logic [8:0]  RELEASE_RESET = 9'h000;
  localparam logic [8:0]  OPERATE_RESET = 9'h1FF;

  // Output format codes
  localparam logic [2:0] FMT_CALIB = 3'h0;
  localparam logic [2:0] FMT_POS   = 3'h4;
  localparam logic [2:0] FMT_NEG   = 3'h5;

  // Signal scale: one code is one offset step, supply is 1023 codes
  localparam logic signed [15:0] OFFSET_ZERO = 16'sh0800;
  localparam logic signed [15:0] SUPPLY_CODE = 16'sh03FF;
  localparam logic [8:0]         RELEASE_MAX = 9'h100;
  localparam int                 GAIN_FRAC   = 14;

  // Busy cycles of a read; the answer comes in the cycle after
  localparam int READ_LATENCY = 2;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_BOOT_WAIT,
    ST_IDLE,
    ST_READ,
    ST_READ_WAIT,
    ST_STORE
  } hscl_state_type;

endpackage : hscl_pkg

/* File: rtl/hscl_nvstore.sv */
/*
  Non-volatile word store: four user information words and the lock word.
  Contents survive reset; read data come out of a register one cycle late.
  Assumes one write and one read per cycle at most.
*/
`timescale 1ns/10ps
module hscl_nvstore
  import hscl_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);

  // Erased cells read as zero on first power
  logic [DATA_W-1:0] cell_mem [0:(1<<ADDR_W)-1] = '{default: '0};

  // No reset on the array: it models cells that keep their charge
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      cell_mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= cell_mem[rd_addr_i];
    end
  end

endmodule : hscl_nvstore

/* File: rtl/hscl_core.sv */
/*
  Configuration, readback and lock logic of a programmable field switch.
  Holds offset, gain, thresholds and output format, runs the processing
  datapath and the hysteresis comparator, and answers decoded commands.
  Assumes the supply telegram decoder and the field filter sit on CLK_I.
*/
`timescale 1ns/10ps
module hscl_core
  import hscl_pkg::*;
(
  input  wire logic              CLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              CMD_VALID_I,
  input  wire logic              CMD_WRITE_I,
  input  wire logic              CMD_STORE_I,
  input  wire logic [ADDR_W-1:0] CMD_ADDR_I,
  input  wire logic [DATA_W-1:0] CMD_WDATA_I,
  input  wire logic [DATA_W-1:0] RAW_SAMPLE_I,
  output logic                   CMD_READY_O,
  output logic                   ANS_VALID_O,
  output logic      [DATA_W-1:0] ANS_DATA_O,
  output logic                   SWITCH_OUT_O,
  output logic                   LOCKED_O
);

  hscl_state_type state_reg;
  hscl_state_type state_next;

  logic [FMT_W-1:0]   format_reg;
  logic [OFFS_W-1:0]  offset_reg;
  logic [GAIN_W-1:0]  gain_reg;
  logic [LEVEL_W-1:0] release_reg;
  logic [LEVEL_W-1:0] operate_reg;
  logic [UIB_W-1:0]   stage_reg [0:UIB_COUNT-1];
  logic               lock_active_reg;
  logic [1:0]         store_idx_reg;
  logic [ADDR_W-1:0]  rd_addr_reg;
  logic               ans_valid_reg;
  logic [DATA_W-1:0]  ans_data_reg;
  logic [DATA_W-1:0]  raw_reg;
  logic [DATA_W-1:0]  proc_reg;
  logic               switch_on_reg;

  logic               cmd_take;
  logic               cmd_wr;
  logic               cmd_rd;
  logic               cmd_store;
  logic               mem_wr_en;
  logic [ADDR_W-1:0]  mem_wr_addr;
  logic [DATA_W-1:0]  mem_wr_data;
  logic [ADDR_W-1:0]  mem_rd_addr;
  logic [DATA_W-1:0]  mem_rd_data;
  logic [DATA_W-1:0]  proc_reversed;
  logic [DATA_W-1:0]  read_value;
  logic [1:0]         uib_idx;
  logic               is_uib;

  logic signed [27:0] product;
  logic signed [15:0] scaled;
  logic signed [15:0] offset_raw;
  logic signed [15:0] offset_eff;
  logic signed [15:0] ceiling;
  logic signed [15:0] sum;
  logic signed [15:0] clipped;
  logic [LEVEL_W-1:0] release_eff;
  logic [DATA_W-1:0]  release_code;
  logic [DATA_W-1:0]  operate_code;

  // Commands are silently dropped once the lock is live
  assign CMD_READY_O = (state_reg == ST_IDLE);
  assign cmd_take    = CMD_VALID_I && CMD_READY_O && !lock_active_reg;
  assign cmd_store   = cmd_take && CMD_STORE_I;
  assign cmd_wr      = cmd_take && !CMD_STORE_I && CMD_WRITE_I;
  assign cmd_rd      = cmd_take && !CMD_STORE_I && !CMD_WRITE_I;
  assign is_uib      = (CMD_ADDR_I >= ADDR_UIB0) && (CMD_ADDR_I <= ADDR_UIB3);
  assign uib_idx     = 2'(CMD_ADDR_I - ADDR_UIB0);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_BOOT: begin
        state_next = ST_BOOT_WAIT;
      end
      ST_BOOT_WAIT: begin
        state_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (cmd_store) begin
          state_next = ST_STORE;
        end else if (cmd_rd) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        state_next = ST_READ_WAIT;
      end
      ST_READ_WAIT: begin
        state_next = ST_IDLE;
      end
      ST_STORE: begin
        if (store_idx_reg == 2'(UIB_COUNT - 1)) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg <= ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Lock state is sampled once per power-up from the stored word
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lock_active_reg <= 1'b0;
    end else if (state_reg == ST_BOOT_WAIT) begin
      lock_active_reg <= mem_rd_data[0];
    end
  end

  assign LOCKED_O = lock_active_reg;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      format_reg  <= FORMAT_RESET;
      offset_reg  <= OFFSET_RESET;
      gain_reg    <= GAIN_RESET;
      release_reg <= RELEASE_RESET;
      operate_reg <= OPERATE_RESET;
    end else if (cmd_wr) begin
      case (CMD_ADDR_I)
        ADDR_FORMAT: begin
          format_reg <= CMD_WDATA_I[FMT_W-1:0];
        end
        ADDR_OFFSET: begin
          offset_reg <= CMD_WDATA_I[OFFS_W-1:0];
        end
        ADDR_GAIN: begin
          gain_reg <= CMD_WDATA_I[GAIN_W-1:0];
        end
        ADDR_RELEASE: begin
          release_reg <= CMD_WDATA_I[LEVEL_W-1:0];
        end
        ADDR_OPERATE: begin
          operate_reg <= CMD_WDATA_I[LEVEL_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Block writes land in staging; only the store commits them
  generate
    for (genvar g = 0; g < UIB_COUNT; g++) begin : gen_stage
      always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          stage_reg[g] <= '0;
        end else if (cmd_wr && is_uib && (uib_idx == 2'(g))) begin
          stage_reg[g] <= CMD_WDATA_I[UIB_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      store_idx_reg <= 2'h0;
    end else if (state_reg == ST_STORE) begin
      store_idx_reg <= store_idx_reg + 2'h1;
    end else begin
      store_idx_reg <= 2'h0;
    end
  end

  // Lock word is written only with bit 0 set, so it can never clear
  always_comb begin
    mem_wr_en   = 1'b0;
    mem_wr_addr = ADDR_LOCK;
    mem_wr_data = '0;
    if (state_reg == ST_STORE) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = ADDR_W'(ADDR_UIB0 + {2'h0, store_idx_reg});
      mem_wr_data = {1'b0, stage_reg[store_idx_reg]};
    end else if (cmd_wr && (CMD_ADDR_I == ADDR_LOCK) && CMD_WDATA_I[0]) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = ADDR_LOCK;
      mem_wr_data = {12'h000, CMD_WDATA_I[1], 1'b1};
    end
  end

  assign mem_rd_addr = (state_reg == ST_BOOT) ? ADDR_LOCK : rd_addr_reg;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_addr_reg <= '0;
    end else if (cmd_rd) begin
      rd_addr_reg <= CMD_ADDR_I;
    end
  end

  hscl_nvstore u_nvstore (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .wr_en_i   (mem_wr_en),
    .wr_addr_i (mem_wr_addr),
    .wr_data_i (mem_wr_data),
    .rd_addr_i (mem_rd_addr),
    .rd_data_o (mem_rd_data)
  );

  // Processing datapath: gain times raw, plus offset, then clipped
  assign product    = $signed(RAW_SAMPLE_I) * $signed(gain_reg);
  assign scaled     = {{2{product[27]}}, product[27:GAIN_FRAC]};
  assign offset_raw = $signed({4'h0, offset_reg}) - OFFSET_ZERO;

  always_comb begin
    offset_eff = offset_raw;
    if (offset_raw > SUPPLY_CODE) begin
      offset_eff = SUPPLY_CODE;
    end else if (offset_raw < -SUPPLY_CODE) begin
      offset_eff = -SUPPLY_CODE;
    end
  end

  assign sum     = scaled + offset_eff;
  assign ceiling = (offset_eff < 16'sh0000) ? SUPPLY_CODE + offset_eff : SUPPLY_CODE;

  always_comb begin
    clipped = sum;
    if (sum > ceiling) begin
      clipped = ceiling;
    end else if (sum < 16'sh0000) begin
      clipped = 16'sh0000;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      raw_reg  <= '0;
      proc_reg <= '0;
    end else begin
      raw_reg  <= RAW_SAMPLE_I;
      proc_reg <= clipped[DATA_W-1:0];
    end
  end

  // Levels step twice as coarse as the signal, hence the shift
  assign release_eff  = (release_reg > RELEASE_MAX) ? RELEASE_MAX : release_reg;
  assign release_code = {4'h0, release_eff, 1'b0};
  assign operate_code = {4'h0, operate_reg, 1'b0};

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      switch_on_reg <= 1'b0;
    end else if (proc_reg > operate_code) begin
      switch_on_reg <= 1'b1;
    end else if (proc_reg < release_code) begin
      switch_on_reg <= 1'b0;
    end else begin
      switch_on_reg <= switch_on_reg;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SWITCH_OUT_O <= 1'b1;
    end else if (format_reg == FMT_NEG) begin
      SWITCH_OUT_O <= switch_on_reg;
    end else begin
      SWITCH_OUT_O <= !switch_on_reg;
    end
  end

  generate
    for (genvar b = 0; b < DATA_W; b++) begin : gen_rev
      assign proc_reversed[b] = proc_reg[DATA_W-1-b];
    end
  endgenerate

  always_comb begin
    read_value = '0;
    case (rd_addr_reg)
      ADDR_FORMAT: begin
        read_value = {11'h000, format_reg};
      end
      ADDR_OFFSET: begin
        read_value = {2'h0, offset_reg};
      end
      ADDR_GAIN: begin
        read_value = gain_reg;
      end
      ADDR_RELEASE: begin
        read_value = {5'h00, release_reg};
      end
      ADDR_OPERATE: begin
        read_value = {5'h00, operate_reg};
      end
      ADDR_RAW: begin
        read_value = raw_reg;
      end
      ADDR_PROC: begin
        read_value = (format_reg == FMT_CALIB) ? proc_reversed : '0;
      end
      default: begin
        read_value = mem_rd_data;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ans_valid_reg <= 1'b0;
      ans_data_reg  <= '0;
    end else if (state_reg == ST_READ_WAIT) begin
      ans_valid_reg <= 1'b1;
      ans_data_reg  <= read_value;
    end else begin
      ans_valid_reg <= 1'b0;
    end
  end

  assign ANS_VALID_O = ans_valid_reg;
  assign ANS_DATA_O  = ans_data_reg;

endmodule : hscl_core

/* File: sim/hscl_core_sva.sv */
/*
  Checker of the hscl_core command, answer and lock ports.
  Assumes one clock and an asynchronous active-low reset; bound below.
*/
`timescale 1ns/10ps
module hscl_core_sva
  import hscl_pkg::*;
(
  input wire logic              CLK_I,
  input wire logic              RESET_N_I,
  input wire logic              CMD_VALID_I,
  input wire logic              CMD_WRITE_I,
  input wire logic              CMD_STORE_I,
  input wire logic [ADDR_W-1:0] CMD_ADDR_I,
  input wire logic [DATA_W-1:0] CMD_WDATA_I,
  input wire logic [DATA_W-1:0] RAW_SAMPLE_I,
  input wire logic              CMD_READY_O,
  input wire logic              ANS_VALID_O,
  input wire logic [DATA_W-1:0] ANS_DATA_O,
  input wire logic              SWITCH_OUT_O,
  input wire logic              LOCKED_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // Locked commands are dropped, so they never count as taken
  wire logic taken = CMD_VALID_I & CMD_READY_O & !LOCKED_O;

  sequence read_s;
    taken && !CMD_STORE_I && !CMD_WRITE_I;
  endsequence
  sequence store_s;
    taken && CMD_STORE_I;
  endsequence
  sequence lock_s;
    taken && !CMD_STORE_I && CMD_WRITE_I && CMD_ADDR_I == ADDR_LOCK && CMD_WDATA_I[0];
  endsequence

  read_answer_a: assert property (read_s |-> ##3 ANS_VALID_O)
    else $error("read answer not on third cycle");
  read_busy_a: assert property (read_s |=> !CMD_READY_O [*2] ##1 CMD_READY_O)
    else $error("ready wrong during read");
  store_busy_a: assert property (store_s |=> !CMD_READY_O [*4] ##1 CMD_READY_O)
    else $error("ready wrong during store");
  ans_pulse_a: assert property (ANS_VALID_O |=> !ANS_VALID_O)
    else $error("answer valid longer than one cycle");
  ans_hold_a: assert property (!ANS_VALID_O |-> $stable(ANS_DATA_O))
    else $error("answer data moved without answer");
  locked_quiet_a: assert property (LOCKED_O |-> !ANS_VALID_O)
    else $error("answer while locked");
  lock_sticky_a: assert property (LOCKED_O |=> LOCKED_O)
    else $error("lock dropped");
  lock_delay_a: assert property (lock_s |=> !LOCKED_O [*4])
    else $error("lock live before power cycle");
  boot_ready_a: assert property ($rose(RESET_N_I) |-> !CMD_READY_O ##1 !CMD_READY_O ##1 CMD_READY_O)
    else $error("ready not after two boot cycles");
endmodule : hscl_core_sva

bind hscl_core hscl_core_sva u_sva (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CMD_VALID_I(CMD_VALID_I), .CMD_WRITE_I(CMD_WRITE_I),
  .CMD_STORE_I(CMD_STORE_I), .CMD_ADDR_I(CMD_ADDR_I), .CMD_WDATA_I(CMD_WDATA_I),
  .RAW_SAMPLE_I(RAW_SAMPLE_I), .CMD_READY_O(CMD_READY_O), .ANS_VALID_O(ANS_VALID_O),
  .ANS_DATA_O(ANS_DATA_O), .SWITCH_OUT_O(SWITCH_OUT_O), .LOCKED_O(LOCKED_O)
);

/* File: sim/hscl_prog_model.sv */
/*
  Programmer model: sends decoded read, write and store commands.
  Assumes one caller at a time; each command is held until ready is seen, at most nine edges.
*/
`timescale 1ns/10ps
module hscl_prog_model
  import hscl_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              ready_i,
  output logic                   valid_o,
  output logic                   write_o,
  output logic                   store_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o
);
  int misses = 0;

  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    store_o = 1'b0;
    addr_o  = 4'h0;
    wdata_o = 14'h0000;
  end

  // Idle gap lets the model be prompt or slow
  task automatic cmd(input logic wr, input logic st, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    valid_o <= 1'b1;
    write_o <= wr;
    store_o <= st;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge clk_i);
    for (int n = 0; n < 8 && ready_i !== 1'b1; n++) @(posedge clk_i);
    // A command that never sees ready is a handshake fault, counted here for the bench
    if (ready_i !== 1'b1) misses++;
    // Idle address and data lines carry junk so nothing leans on their stale values
    valid_o <= 1'b0;
    store_o <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : cmd
endmodule : hscl_prog_model

/* File: sim/hscl_core_tb.sv */
/*
  Bench of hscl_core: a programmer model sends commands, a watcher
  compares answers with queued notes. Assumes the checker binds itself.
*/
`timescale 1ns/10ps
module hscl_core_tb
  import hscl_pkg::*;
;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              valid;
  logic              wr_en;
  logic              store;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] raw = 14'h0000;
  logic              ready;
  logic              ans_v;
  logic [DATA_W-1:0] ans_d;
  logic              sw;
  logic              locked;
  logic [31:0]       seed = 32'h9D615C33;
  logic [14:0]       notes[$];
  logic [13:0]       blk[4];
  logic [13:0]       gain_tab[4] = '{14'h03B6, 14'h0266, 14'h0291, 14'h0521};
  logic [13:0]       offs_tab[2] = '{14'h0A00, 14'h060C};
  int                errors = 0;
  int                comparisons = 0;

  hscl_core dut (
    .CLK_I(clk), .RESET_N_I(reset_n), .CMD_VALID_I(valid), .CMD_WRITE_I(wr_en),
    .CMD_STORE_I(store), .CMD_ADDR_I(addr), .CMD_WDATA_I(wdata), .RAW_SAMPLE_I(raw),
    .CMD_READY_O(ready), .ANS_VALID_O(ans_v), .ANS_DATA_O(ans_d), .SWITCH_OUT_O(sw),
    .LOCKED_O(locked)
  );
  hscl_prog_model prog (
    .clk_i(clk), .ready_i(ready), .valid_o(valid), .write_o(wr_en), .store_o(store),
    .addr_o(addr), .wdata_o(wdata)
  );

  initial forever #12.5 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [13:0] rev(input logic [13:0] v);
    foreach (v[i]) rev[i] = v[13-i];
  endfunction : rev

  // Offset binary addend, clipped to supply less any negative offset
  function automatic logic [13:0] proc_f(input int r, input int g, input int o);
    int p;
    o = o - OFFSET_ZERO;
    o = (o > SUPPLY_CODE) ? SUPPLY_CODE : (o < -SUPPLY_CODE) ? -SUPPLY_CODE : o;
    p = ((r * g) >>> GAIN_FRAC) + o;
    p = (p < 0) ? 0 : p;
    p = (p > SUPPLY_CODE + ((o < 0) ? o : 0)) ? SUPPLY_CODE + ((o < 0) ? o : 0) : p;
    return p[13:0];
  endfunction : proc_f

  task automatic rd(input logic [3:0] a, input logic [13:0] e, input logic r);
    notes.push_back({r, e});
    prog.cmd(1'b0, 1'b0, a, 14'(xs()), xs() % 3);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [13:0] d);
    prog.cmd(1'b1, 1'b0, a, d, xs() % 3);
  endtask : wr

  task automatic power_cycle();
    // Let a pending read answer land before the supply drops
    for (int n = 0; n < 8 && notes.size() != 0; n++) @(posedge clk);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : power_cycle

  task automatic sw_chk(input logic [11:0] off, input logic e);
    wr(ADDR_OFFSET, {2'b00, off});
    repeat (6) @(posedge clk);
    check("switch", {13'h0, sw}, {13'h0, e});
  endtask : sw_chk

  // Whole walk 0..3 then one store, even when one block changes
  task automatic uib_update();
    foreach (blk[i]) wr(4'(ADDR_UIB0 + i), blk[i]);
    prog.cmd(1'b0, 1'b1, 4'(xs()), 14'(xs()), 0);
    foreach (blk[i]) rd(4'(ADDR_UIB0 + i), {1'b0, blk[i][12:0]}, 1'b0);
  endtask : uib_update

  task automatic report_and_stop();
    errors += prog.misses;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin : watch
    logic [14:0] n;
    if (ans_v === 1'b1) begin
      if (notes.size() == 0) check("spare answer", 14'h0001, 14'h0000);
      else begin
        n = notes.pop_front();
        check("answer", n[14] ? rev(ans_d) : ans_d, n[13:0]);
      end
    end
  end

  initial begin
    #500000;
    errors++;
    report_and_stop();
  end

  initial begin
    power_cycle();
    wr(ADDR_FORMAT, 14'h0000);
    wr(ADDR_OFFSET, 14'h0800);
    wr(ADDR_RELEASE, 14'h0000);
    wr(ADDR_OPERATE, 14'h01FF);
    foreach (gain_tab[i]) begin
      wr(ADDR_GAIN, gain_tab[i]);
      raw <= 14'(xs());
      repeat (4) @(posedge clk);
      rd(ADDR_RAW, raw, 1'b0);
      rd(ADDR_PROC, proc_f($signed(raw), $signed(gain_tab[i]), 12'h800), 1'b1);
    end
    wr(ADDR_GAIN, 14'h1FFF);
    raw <= 14'h1FFF;
    foreach (offs_tab[i]) begin
      wr(ADDR_OFFSET, offs_tab[i]);
      repeat (4) @(posedge clk);
      rd(ADDR_PROC, proc_f(32'h1FFF, 32'h1FFF, offs_tab[i]), 1'b1);
    end
    wr(ADDR_FORMAT, {11'h0, FMT_POS});
    rd(ADDR_PROC, 14'h0000, 1'b1);
    rd(4'hC, 14'h0000, 1'b0);
    wr(ADDR_GAIN, 14'h0000);
    wr(ADDR_RELEASE, 14'h0064);
    wr(ADDR_OPERATE, 14'h00C8);
    sw_chk(12'hA58, 1'b0);
    sw_chk(12'h92C, 1'b0);
    sw_chk(12'h864, 1'b1);
    sw_chk(12'h92C, 1'b1);
    wr(ADDR_FORMAT, {11'h0, FMT_NEG});
    sw_chk(12'h92C, 1'b0);
    wr(ADDR_RELEASE, 14'h012C);
    wr(ADDR_OPERATE, 14'h0190);
    sw_chk(12'hB84, 1'b1);
    sw_chk(12'hA26, 1'b1);
    foreach (blk[i]) blk[i] = 14'(xs());
    foreach (blk[i]) wr(4'(ADDR_UIB0 + i), blk[i]);
    foreach (blk[i]) rd(4'(ADDR_UIB0 + i), 14'h0000, 1'b0);
    uib_update();
    power_cycle();
    foreach (blk[i]) rd(4'(ADDR_UIB0 + i), {1'b0, blk[i][12:0]}, 1'b0);
    blk[2] = 14'(xs());
    uib_update();
    wr(ADDR_LOCK, 14'h0002);
    rd(ADDR_LOCK, 14'h0000, 1'b0);
    wr(ADDR_LOCK, 14'h0003);
    rd(ADDR_LOCK, 14'h0003, 1'b0);
    check("locked", {13'h0, locked}, 14'h0000);
    raw <= 14'h0000;
    power_cycle();
    check("locked", {13'h0, locked}, 14'h0001);
    prog.cmd(1'b0, 1'b0, ADDR_RAW, 14'h0000, 0);
    wr(ADDR_LOCK, 14'h0000);
    wr(ADDR_FORMAT, {11'h0, FMT_NEG});
    repeat (6) @(posedge clk);
    check("switch", {13'h0, sw}, 14'h0001);
    power_cycle();
    check("locked", {13'h0, locked}, 14'h0001);
    check("pending", 14'(notes.size()), 14'h0000);
    report_and_stop();
  end
endmodule : hscl_core_tb
